// >>> design/lbc_defines.vh
`ifndef LBC_DEFINES_VH
`define LBC_DEFINES_VH

// ----------------------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------------------
`define LBC_IDX_B_RX_VALID     16'h7617
`define LBC_IDX_B_RX_ERROR     16'h761f
`define LBC_IDX_B_TX_COUNT     16'h7627
`define LBC_IDX_B_CONFIG       16'h9d3f
`define LBC_IDX_B_BCAST_LEVEL  16'h9d4b
`define LBC_IDX_A_FADE_SPEED   16'h9e0e
`define LBC_IDX_A_FADE_DUR     16'h9e12
`define LBC_IDX_A_POWERUP      16'h9e16
`define LBC_IDX_A_FAULT        16'h9e1a

// ----------------------------------------------------------------------------
// config field positions and reset values
// ----------------------------------------------------------------------------
`define LBC_CFG_LAMP_STATE     0
`define LBC_CFG_RECALL_ALL     1
`define LBC_CFG_ALL_OFF        2
`define LBC_CFG_SENSOR_GATE    3
`define LBC_CFG_DIM_DISABLE    4
`define LBC_CFG_WIDTH          5
`define LBC_RST_CONFIG         5'h08
`define LBC_RST_BCAST_LEVEL    16'h0000
`define LBC_RST_FADE_SPEED     4'h7
`define LBC_RST_FADE_DUR       4'h0
`define LBC_RST_POWERUP        16'h00fe
`define LBC_RST_FAULT          16'h00fe

// ----------------------------------------------------------------------------
// bus commands and fade figures
// ----------------------------------------------------------------------------
`define LBC_KIND_OFF           3'h0
`define LBC_KIND_RECALL        3'h1
`define LBC_KIND_LEVEL         3'h2
`define LBC_KIND_POWERUP       3'h3
`define LBC_KIND_FAULT         3'h4
`define LBC_BCAST_ADDR         8'hff
`define LBC_IFACE_A            1'b0
`define LBC_IFACE_B            1'b1
`define LBC_FADE_STEPS         254
`define LBC_TENTHS_PER_SEC     10

`endif

// >>> design/lbc_regs.v
// Function
// - fade speed code 0 means no fade; codes 1..15 map to 0.7..90.5 s fade times.
// - a fade covers levels 0 to 254; step rate is 254 over fade time.
// - in joint mode interface A uses interface B fade speed.
// - in joint mode interface A uses interface B fade duration.
// - fade duration accompanies only supervisor-issued setpoint commands; the code sends it with every interface B command (off, recall, level).
// - fade duration codes share the fade speed time table.
// - power-up level is sent to interface A ballasts; defaults to 254.
// - fault level is sent to interface A ballasts; defaults to 254.
// - 32-bit count of valid frames received on interface B, zero at reset.
// - 32-bit count of error frames received on interface B, zero at reset.
// - 32-bit count of frames transmitted on interface B, zero at reset.
// - config bit 0 reads 1 while ballasts are on, 0 while off.
// - a falling bit 0 sends broadcast off; a rising bit 0 sends broadcast recall.
// - a rising bit 1 sends broadcast recall-last-scene to interface B.
// - a rising bit 2 sends broadcast off to interface B.
// - bit 3 gates sensor input B; defaults to 1.
// - bit 4 set disables switch B dimming, leaving on/off toggling.
// - broadcast level is sent to all interface B ballasts; defaults to 0.
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
`include "lbc_defines.vh"

module lbc_regs #(
  parameter CLK_HZ = 125000000
) (
  // clock and reset
  input  wire        CLK_SYS,
  input  wire        SYS_RST,
  // wishbone slave
  input  wire        WB_CYC,
  input  wire        WB_STB,
  input  wire        WB_WE,
  input  wire [17:0] WB_ADR,
  input  wire [3:0]  WB_SEL,
  input  wire [31:0] WB_DAT_I,
  output reg  [31:0] WB_DAT_O,
  output reg         WB_ACK,
  // pins
  input  wire        SENSOR_INPUT_B,
  input  wire        SWITCH_INPUT_B,
  input  wire        JOINT_MODE,
  // link-side events and state
  input  wire        B_RX_VALID_STB,
  input  wire        B_RX_ERROR_STB,
  input  wire        B_TX_STB,
  input  wire        B_LAMP_UPD,
  input  wire        B_LAMP_ON,
  input  wire [3:0]  IFACE_B_FADE_SPEED,
  input  wire [3:0]  IFACE_B_FADE_DURATION,
  // command queue toward the bus framer
  output reg         CMD_VALID,
  input  wire        CMD_READY,
  output reg         CMD_IFACE,
  output reg  [2:0]  CMD_KIND,
  output reg  [7:0]  CMD_ADDR,
  output reg  [7:0]  CMD_ARG,
  output reg  [3:0]  CMD_FADE,
  // control outputs
  output reg         SENSOR_B_ACTIVE,
  output reg         SWITCH_B_DIM_EN,
  output reg         SWITCH_B_LEVEL,
  output reg  [3:0]  FADE_A_SPEED_CODE,
  output reg  [31:0] FADE_A_STEP_CYCLES
);

  // --------------------------------------------------------------------------
  // fade table
  // --------------------------------------------------------------------------
  // fade time in tenths of a second per code; 0 means no fade
  function [9:0] fade_tenths;
    input [3:0] code;
    begin
      case (code)
        4'h1:    fade_tenths = 10'd7;
        4'h2:    fade_tenths = 10'd10;
        4'h3:    fade_tenths = 10'd14;
        4'h4:    fade_tenths = 10'd20;
        4'h5:    fade_tenths = 10'd28;
        4'h6:    fade_tenths = 10'd40;
        4'h7:    fade_tenths = 10'd57;
        4'h8:    fade_tenths = 10'd80;
        4'h9:    fade_tenths = 10'd113;
        4'ha:    fade_tenths = 10'd160;
        4'hb:    fade_tenths = 10'd226;
        4'hc:    fade_tenths = 10'd320;
        4'hd:    fade_tenths = 10'd453;
        4'he:    fade_tenths = 10'd640;
        4'hf:    fade_tenths = 10'd905;
        default: fade_tenths = 10'd0;
      endcase
    end
  endfunction

  // clock cycles between level steps; 64-bit math since time * rate overflows 32 bits
  function [31:0] step_cycles;
    input [3:0] code;
    reg   [63:0] prod;
    begin
      prod        = {54'h0, fade_tenths(code)} * CLK_HZ;
      prod        = prod / (`LBC_TENTHS_PER_SEC * `LBC_FADE_STEPS);
      step_cycles = prod[31:0];
    end
  endfunction

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  reg [2:0] pin_s1_q;
  reg [2:0] pin_s2_q;

  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end else begin
      pin_s1_q <= {JOINT_MODE, SWITCH_INPUT_B, SENSOR_INPUT_B};
      pin_s2_q <= pin_s1_q;
    end
  end

  // --------------------------------------------------------------------------
  // wishbone decode
  // --------------------------------------------------------------------------
  wire [15:0] idx    = WB_ADR[17:2];
  wire        access = WB_CYC & WB_STB & ~WB_ACK;
  wire        wr_lo  = access & WB_WE & WB_SEL[0];
  wire        wr_hi  = access & WB_WE & WB_SEL[1];
  wire        wr_any = wr_lo | wr_hi;

  reg  [`LBC_CFG_WIDTH-1:0] cfg_q;
  reg  [15:0] bcast_level_q;
  reg  [3:0]  a_speed_q;
  reg  [3:0]  a_dur_q;
  reg  [15:0] a_powerup_q;
  reg  [15:0] a_fault_q;
  reg  [31:0] cnt_rx_valid_q;
  reg  [31:0] cnt_rx_error_q;
  reg  [31:0] cnt_tx_q;

  wire [15:0] wd16 = {wr_hi ? WB_DAT_I[15:8] : 8'h00, WB_DAT_I[7:0]};

  function [15:0] merge16;
    input [15:0] old;
    input [15:0] nw;
    input [1:0]  sel;
    begin
      merge16 = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
    end
  endfunction

  // --------------------------------------------------------------------------
  // config register and edge detection
  // --------------------------------------------------------------------------
  wire cfg_wr   = wr_lo & (idx == `LBC_IDX_B_CONFIG);
  wire lvl_wr   = wr_any & (idx == `LBC_IDX_B_BCAST_LEVEL);
  wire pwr_wr   = wr_any & (idx == `LBC_IDX_A_POWERUP);
  wire flt_wr   = wr_any & (idx == `LBC_IDX_A_FAULT);
  wire st_fall  = cfg_wr & cfg_q[`LBC_CFG_LAMP_STATE] & ~WB_DAT_I[`LBC_CFG_LAMP_STATE];
  wire st_rise  = cfg_wr & ~cfg_q[`LBC_CFG_LAMP_STATE] & WB_DAT_I[`LBC_CFG_LAMP_STATE];
  wire rc_rise  = cfg_wr & ~cfg_q[`LBC_CFG_RECALL_ALL] & WB_DAT_I[`LBC_CFG_RECALL_ALL];
  wire off_rise = cfg_wr & ~cfg_q[`LBC_CFG_ALL_OFF] & WB_DAT_I[`LBC_CFG_ALL_OFF];

  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      cfg_q <= `LBC_RST_CONFIG;
    end else if (cfg_wr) begin
      cfg_q <= WB_DAT_I[`LBC_CFG_WIDTH-1:0];
    end else if (B_LAMP_UPD) begin
      cfg_q[`LBC_CFG_LAMP_STATE] <= B_LAMP_ON;
    end
  end

  // --------------------------------------------------------------------------
  // plain registers and frame counters
  // --------------------------------------------------------------------------
  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      bcast_level_q  <= `LBC_RST_BCAST_LEVEL;
      a_speed_q      <= `LBC_RST_FADE_SPEED;
      a_dur_q        <= `LBC_RST_FADE_DUR;
      a_powerup_q    <= `LBC_RST_POWERUP;
      a_fault_q      <= `LBC_RST_FAULT;
      cnt_rx_valid_q <= 32'h0;
      cnt_rx_error_q <= 32'h0;
      cnt_tx_q       <= 32'h0;
    end else begin
      if (lvl_wr) begin
        bcast_level_q <= merge16(bcast_level_q, wd16, WB_SEL[1:0]);
      end
      if (pwr_wr) begin
        a_powerup_q <= merge16(a_powerup_q, wd16, WB_SEL[1:0]);
      end
      if (flt_wr) begin
        a_fault_q <= merge16(a_fault_q, wd16, WB_SEL[1:0]);
      end
      if (wr_lo && idx == `LBC_IDX_A_FADE_SPEED) begin
        a_speed_q <= WB_DAT_I[3:0];
      end
      if (wr_lo && idx == `LBC_IDX_A_FADE_DUR) begin
        a_dur_q <= WB_DAT_I[3:0];
      end
      if (B_RX_VALID_STB) begin
        cnt_rx_valid_q <= cnt_rx_valid_q + 32'h1;
      end
      if (B_RX_ERROR_STB) begin
        cnt_rx_error_q <= cnt_rx_error_q + 32'h1;
      end
      if (B_TX_STB) begin
        cnt_tx_q <= cnt_tx_q + 32'h1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // read mux and ack
  // --------------------------------------------------------------------------
  reg [31:0] rd_d;

  always @* begin
    case (idx)
      `LBC_IDX_B_RX_VALID:    rd_d = cnt_rx_valid_q;
      `LBC_IDX_B_RX_ERROR:    rd_d = cnt_rx_error_q;
      `LBC_IDX_B_TX_COUNT:    rd_d = cnt_tx_q;
      `LBC_IDX_B_CONFIG:      rd_d = {27'h0, cfg_q};
      `LBC_IDX_B_BCAST_LEVEL: rd_d = {16'h0, bcast_level_q};
      `LBC_IDX_A_FADE_SPEED:  rd_d = {28'h0, a_speed_q};
      `LBC_IDX_A_FADE_DUR:    rd_d = {28'h0, a_dur_q};
      `LBC_IDX_A_POWERUP:     rd_d = {16'h0, a_powerup_q};
      `LBC_IDX_A_FAULT:       rd_d = {16'h0, a_fault_q};
      default:                rd_d = 32'h0;
    endcase
  end

  // unmapped addresses still ack with zero so a stray access never hangs the master
  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      WB_ACK   <= 1'b0;
      WB_DAT_O <= 32'h0;
    end else begin
      WB_ACK   <= access;
      WB_DAT_O <= access ? rd_d : 32'h0;
    end
  end

  // --------------------------------------------------------------------------
  // command queue
  // --------------------------------------------------------------------------
  // one pending flag per source, so coincident edges from one write never merge
  localparam P_ST_OFF = 0;
  localparam P_ST_RC  = 1;
  localparam P_RC     = 2;
  localparam P_OFF    = 3;
  localparam P_LVL    = 4;
  localparam P_PWR    = 5;
  localparam P_FLT    = 6;
  localparam NPEND    = 7;

  reg  [NPEND-1:0] pend_q;
  reg  [NPEND-1:0] pick;
  wire [NPEND-1:0] pend_set = {flt_wr, pwr_wr, lvl_wr, off_rise, rc_rise, st_rise, st_fall};
  wire             slot_free = ~CMD_VALID | CMD_READY;
  wire             joint     = pin_s2_q[2];
  wire [3:0]       eff_speed = joint ? IFACE_B_FADE_SPEED : a_speed_q;
  wire [3:0]       eff_dur   = joint ? IFACE_B_FADE_DURATION : a_dur_q;
  integer          i;

  always @* begin
    pick = {NPEND{1'b0}};
    for (i = NPEND - 1; i >= 0; i = i - 1) begin
      if (pend_q[i]) begin
        pick = {NPEND{1'b0}};
        pick[i] = 1'b1;
      end
    end
  end

  // set wins over the clear when a new edge lands as its flag is taken
  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      pend_q <= {NPEND{1'b0}};
    end else begin
      pend_q <= (pend_q & ~(slot_free ? pick : {NPEND{1'b0}})) | pend_set;
    end
  end

  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      CMD_VALID <= 1'b0;
      CMD_IFACE <= `LBC_IFACE_B;
      CMD_KIND  <= `LBC_KIND_OFF;
      CMD_ADDR  <= `LBC_BCAST_ADDR;
      CMD_ARG   <= 8'h00;
      CMD_FADE  <= 4'h0;
    end else if (slot_free) begin
      CMD_VALID <= |pend_q;
      CMD_ADDR  <= `LBC_BCAST_ADDR;
      CMD_FADE  <= eff_dur;
      CMD_ARG   <= 8'h00;
      CMD_IFACE <= `LBC_IFACE_B;
      if (pick[P_ST_OFF] || pick[P_OFF]) begin
        CMD_KIND <= `LBC_KIND_OFF;
      end else if (pick[P_ST_RC] || pick[P_RC]) begin
        CMD_KIND <= `LBC_KIND_RECALL;
      end else if (pick[P_LVL]) begin
        CMD_KIND <= `LBC_KIND_LEVEL;
        CMD_ARG  <= bcast_level_q[7:0];
      end else if (pick[P_PWR]) begin
        CMD_KIND  <= `LBC_KIND_POWERUP;
        CMD_IFACE <= `LBC_IFACE_A;
        CMD_ARG   <= a_powerup_q[7:0];
        CMD_FADE  <= 4'h0;
      end else begin
        CMD_KIND  <= `LBC_KIND_FAULT;
        CMD_IFACE <= `LBC_IFACE_A;
        CMD_ARG   <= a_fault_q[7:0];
        CMD_FADE  <= 4'h0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // control outputs
  // --------------------------------------------------------------------------
  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      SENSOR_B_ACTIVE    <= 1'b0;
      SWITCH_B_DIM_EN    <= 1'b0;
      SWITCH_B_LEVEL     <= 1'b0;
      FADE_A_SPEED_CODE  <= `LBC_RST_FADE_SPEED;
      FADE_A_STEP_CYCLES <= 32'h0;
    end else begin
      SENSOR_B_ACTIVE    <= pin_s2_q[0] & cfg_q[`LBC_CFG_SENSOR_GATE];
      SWITCH_B_DIM_EN    <= ~cfg_q[`LBC_CFG_DIM_DISABLE];
      SWITCH_B_LEVEL     <= pin_s2_q[1];
      FADE_A_SPEED_CODE  <= eff_speed;
      FADE_A_STEP_CYCLES <= step_cycles(eff_speed);
    end
  end

endmodule // lbc_regs

// >>> dv/lbc_regs_properties.sv
`timescale 1ns/1ps
`include "lbc_defines.vh"
module lbc_regs_properties (
  // clock, reset and bus
  input logic        CLK_SYS, SYS_RST, WB_CYC, WB_STB, WB_WE, WB_ACK,
  input logic [17:0] WB_ADR,
  input logic [3:0]  WB_SEL,
  input logic [31:0] WB_DAT_I, WB_DAT_O,
  // joint fade, dim enable and command port
  input logic        JOINT_MODE, CMD_VALID, CMD_READY, CMD_IFACE, SWITCH_B_DIM_EN,
  input logic [3:0]  IFACE_B_FADE_SPEED, FADE_A_SPEED_CODE, CMD_FADE,
  input logic [2:0]  CMD_KIND,
  input logic [7:0]  CMD_ADDR, CMD_ARG
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  sequence s_req; WB_CYC && WB_STB && !WB_ACK; endsequence
  sequence s_cfg_wr; s_req ##0 (WB_WE && WB_ADR[17:2] == `LBC_IDX_B_CONFIG && WB_SEL[0]) ##1 1; endsequence
  property p_ack; s_req |=> WB_ACK; endproperty
  property p_ack_drop; WB_ACK |=> !WB_ACK; endproperty
  property p_dat_idle; !WB_ACK |-> WB_DAT_O == 32'h0; endproperty
  property p_dim; s_cfg_wr |=> SWITCH_B_DIM_EN == !$past(WB_DAT_I[4], 2); endproperty
  property p_hold; CMD_VALID && !CMD_READY |=> CMD_VALID && $stable({CMD_KIND, CMD_ARG, CMD_FADE}); endproperty
  property p_bcast; CMD_VALID |-> CMD_ADDR == 8'hff; endproperty
  property p_iface; CMD_VALID |-> CMD_IFACE == (CMD_KIND <= 3'h2); endproperty
  property p_noarg; CMD_VALID && CMD_KIND <= 3'h1 |-> CMD_ARG == 8'h0; endproperty
  property p_joint;
    (JOINT_MODE && $stable(IFACE_B_FADE_SPEED))[*5] |-> FADE_A_SPEED_CODE == IFACE_B_FADE_SPEED;
  endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  a_ack_drop: assert property (p_ack_drop) else $error("ack too long");
  a_dat_idle: assert property (p_dat_idle) else $error("read data without ack");
  a_dim: assert property (p_dim) else $error("dim enable wrong");
  a_hold: assert property (p_hold) else $error("command changed while waiting");
  a_bcast: assert property (p_bcast) else $error("command not broadcast");
  a_iface: assert property (p_iface) else $error("command interface wrong");
  a_noarg: assert property (p_noarg) else $error("command argument set");
  a_joint: assert property (p_joint) else $error("joint speed ignored");
endmodule // lbc_regs_properties
bind lbc_regs lbc_regs_properties u_chk (.*);

// >>> dv/lbc_framer_model.sv
`timescale 1ns/1ps
module lbc_framer_model (
  input  logic       clk, rst, valid, slow, iface,
  input  logic [2:0] kind,
  input  logic [7:0] addr, arg,
  input  logic [3:0] fade,
  output logic       ready
);
  logic [23:0] q[$];
  // slow mode stalls every other cycle so held commands get exercised
  always @(posedge clk) begin
    if (rst) begin
      ready <= 1'b0;
    end else begin
      ready <= slow ? ~ready : 1'b1;
      if (valid && ready) q.push_back({iface, kind, addr, arg, fade});
    end
  end
endmodule // lbc_framer_model

// >>> dv/lbc_regs_tb_top.sv
`timescale 1ns/1ps
`include "lbc_defines.vh"
module lbc_regs_tb_top;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, sen = 0, sw = 0, joint = 0;
  logic rxv = 0, rxe = 0, txs = 0, upd = 0, lon = 0, slow = 0;
  logic ack, valid, ready, iface, sact, dimen, swlvl;
  logic [17:0] adr = 0;
  logic [3:0]  sel = 0, bspd = 0, bdur = 0, fcode, cfade;
  logic [31:0] wdat = 0, rdat, steps, rv;
  logic [2:0]  kind;
  logic [7:0]  caddr, carg;
  int fail_count = 0, num_checks = 0;
  int tt[16] = '{0, 7, 10, 14, 20, 28, 40, 57, 80, 113, 160, 226, 320, 453, 640, 905};
  always #4 clk = ~clk;
  lbc_regs #(.CLK_HZ(2540)) DUT (.CLK_SYS(clk), .SYS_RST(rst), .WB_CYC(cyc), .WB_STB(stb), .WB_WE(we),
    .WB_ADR(adr), .WB_SEL(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK(ack), .SENSOR_INPUT_B(sen),
    .SWITCH_INPUT_B(sw), .JOINT_MODE(joint), .B_RX_VALID_STB(rxv), .B_RX_ERROR_STB(rxe), .B_TX_STB(txs),
    .B_LAMP_UPD(upd), .B_LAMP_ON(lon), .IFACE_B_FADE_SPEED(bspd), .IFACE_B_FADE_DURATION(bdur),
    .CMD_VALID(valid), .CMD_READY(ready), .CMD_IFACE(iface), .CMD_KIND(kind), .CMD_ADDR(caddr),
    .CMD_ARG(carg), .CMD_FADE(cfade), .SENSOR_B_ACTIVE(sact), .SWITCH_B_DIM_EN(dimen),
    .SWITCH_B_LEVEL(swlvl), .FADE_A_SPEED_CODE(fcode), .FADE_A_STEP_CYCLES(steps));
  lbc_framer_model M (.clk(clk), .rst(rst), .valid(valid), .slow(slow), .iface(iface), .kind(kind),
    .addr(caddr), .arg(carg), .fade(cfade), .ready(ready));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  // classic cycle: hold until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [15:0] i, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w; adr <= {i, 2'b00}; wdat <= d; sel <= 4'hf;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
    rv = rdat;
    cyc <= 0; stb <= 0;
    if (n >= 20) chk(0, 1);
  endtask
  task automatic rd(input logic [15:0] i, input logic [31:0] e);
    wb(0, i, 0);
    chk(rv, e);
  endtask
  task automatic cmd(input logic [23:0] e);
    repeat (100) if (M.q.size() == 0) @(posedge clk);
    if (M.q.size() == 0) chk(0, 1);
    else chk({8'h0, M.q.pop_front()}, {8'h0, e});
  endtask
  // one-cycle link strobes, one per frame; no ref argument so the nonblocking drive stays on a static variable
  task automatic pulse(input int nv, input int ne, input int nt);
    repeat (nv) begin @(posedge clk); rxv <= 1; @(posedge clk); rxv <= 0; end
    repeat (ne) begin @(posedge clk); rxe <= 1; @(posedge clk); rxe <= 0; end
    repeat (nt) begin @(posedge clk); txs <= 1; @(posedge clk); txs <= 0; end
  endtask
  task t_reset;
    rd(`LBC_IDX_B_RX_VALID, 0);
    rd(`LBC_IDX_B_RX_ERROR, 0);
    rd(`LBC_IDX_B_TX_COUNT, 0);
    rd(`LBC_IDX_B_CONFIG, 32'h08);
    rd(`LBC_IDX_B_BCAST_LEVEL, 0);
    rd(`LBC_IDX_A_FADE_SPEED, 32'h7);
    rd(`LBC_IDX_A_FADE_DUR, 0);
    rd(`LBC_IDX_A_POWERUP, 32'hfe);
    rd(`LBC_IDX_A_FAULT, 32'hfe);
    wb(1, 16'h0001, 32'h55);
    rd(16'h0001, 0);
    $display("reset test done");
  endtask
  task t_count;
    pulse(3, 2, 1);
    wb(1, `LBC_IDX_B_RX_VALID, 32'h5);
    rd(`LBC_IDX_B_RX_VALID, 3);
    rd(`LBC_IDX_B_RX_ERROR, 2);
    rd(`LBC_IDX_B_TX_COUNT, 1);
    $display("counter test done");
  endtask
  task t_cfg;
    slow <= 1;
    wb(1, `LBC_IDX_A_FADE_DUR, 32'h5);
    wb(1, `LBC_IDX_B_CONFIG, 32'h07);
    cmd({1'b1, 3'h1, 8'hff, 8'h0, 4'h5});
    cmd({1'b1, 3'h1, 8'hff, 8'h0, 4'h5});
    cmd({1'b1, 3'h0, 8'hff, 8'h0, 4'h5});
    wb(1, `LBC_IDX_B_CONFIG, 32'h06);
    cmd({1'b1, 3'h0, 8'hff, 8'h0, 4'h5});
    @(posedge clk); lon <= 1; upd <= 1;
    @(posedge clk); upd <= 0;
    rd(`LBC_IDX_B_CONFIG, 32'h07);
    sen <= 1; sw <= 1;
    repeat (5) @(posedge clk);
    chk(sact, 0);
    wb(1, `LBC_IDX_B_CONFIG, 32'h1f);
    repeat (5) @(posedge clk);
    chk(sact, 1);
    chk(dimen, 0);
    chk(swlvl, 1);
    chk(M.q.size(), 0);
    $display("config test done");
  endtask
  task t_levels;
    wb(1, `LBC_IDX_B_BCAST_LEVEL, 32'h80);
    cmd({1'b1, 3'h2, 8'hff, 8'h80, 4'h5});
    wb(1, `LBC_IDX_A_POWERUP, 32'h40);
    cmd({1'b0, 3'h3, 8'hff, 8'h40, 4'h0});
    wb(1, `LBC_IDX_A_FAULT, 32'h20);
    cmd({1'b0, 3'h4, 8'hff, 8'h20, 4'h0});
    rd(`LBC_IDX_B_BCAST_LEVEL, 32'h80);
    $display("level test done");
  endtask
  task t_fade;
    for (int c = 0; c < 16; c++) begin
      wb(1, `LBC_IDX_A_FADE_SPEED, c);
      repeat (3) @(posedge clk);
      chk(fcode, c);
      chk(steps, tt[c]);
    end
    bspd <= 3; bdur <= 9; joint <= 1;
    repeat (6) @(posedge clk);
    chk(fcode, 3);
    chk(steps, 14);
    wb(1, `LBC_IDX_B_BCAST_LEVEL, 32'h10);
    cmd({1'b1, 3'h2, 8'hff, 8'h10, 4'h9});
    $display("fade test done");
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    t_reset(); t_count(); t_cfg(); t_levels(); t_fade();
    summarize();
  end
  initial begin
    #400000;
    fail_count++;
    summarize();
  end
endmodule // lbc_regs_tb_top
